// ### include/tts_pkg.sv
package tts_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // clock and timing
  localparam int unsigned CLK_PERIOD_PS    = 5000;
  localparam int unsigned MEM_POLL_TIME_US = 100;
  localparam int unsigned MEM_POLL_CYCLES  = (MEM_POLL_TIME_US * 1000000) / CLK_PERIOD_PS;
  localparam int unsigned STRAP_SETTLE_NS  = 100;
  localparam int unsigned STRAP_SETTLE_CYC = (STRAP_SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  ////////////////////////////////////////////////////////////////////////////
  // strap layout and on-die pull defaults
  localparam int unsigned SOCK_ID_W         = 2;
  localparam logic [1:0]  LEGACY_SOCKET_SELECT_STRAP  = 2'h0;
  localparam logic [1:0]  SOCK_ID_PULL      = 2'h0;
  localparam logic        TRUST_AGENT_PULL  = 1'h0;
  localparam logic        TRUST_PLAT_PULL   = 1'h1;
  localparam logic        FW_AGENT_PULL     = 1'h0;

  // position of each pin in the device's synchroniser vector
  localparam int unsigned PIN_FW_AGENT   = 0;
  localparam int unsigned PIN_TRUST_PLAT = 1;
  localparam int unsigned PIN_TRUST_AGT  = 2;
  localparam int unsigned PIN_SOCK_LO    = 3;
  localparam int unsigned PIN_SOCK_HI    = 4;
  localparam int unsigned PIN_HARD_RSTN  = 5;
  localparam int unsigned PIN_SUPPLY_OK  = 6;
  localparam int unsigned PIN_COUNT      = 7;
  localparam logic [6:0]  PIN_SYNC_RESET = 7'h00;

  ////////////////////////////////////////////////////////////////////////////
  // derived socket settings
  localparam logic [7:0]  MGMT_ADDR_BASE  = 8'h30;
  localparam int unsigned MEM_TEMP_W      = 8;
  localparam int unsigned MEM_MODULES     = 4;

endpackage : tts_pkg

// ### include/tts_if.sv
`timescale 1ns/100ps
interface tts_if;
  import tts_pkg::*;

  // device pin, push-pull
  logic                 thermal_shutdown_n;
  // board driven levels
  logic                 supply_ok_in;
  logic                 hard_reset_n;
  // strap drivers from the board and their enables
  logic [SOCK_ID_W-1:0] socket_select_drv;
  logic [SOCK_ID_W-1:0] socket_select_oe;
  logic                 trust_agent_drv;
  logic                 trust_agent_oe;
  logic                 trust_platform_drv;
  logic                 trust_platform_oe;
  logic                 firmware_agent_drv;
  logic                 firmware_agent_oe;
  // strap levels as the device sees them, pulls fill undriven pins
  logic [SOCK_ID_W-1:0] socket_select_strap;
  logic                 trust_agent_strap;
  logic                 trust_platform_strap;
  logic                 firmware_agent_strap;

  assign socket_select_strap  = (socket_select_oe & socket_select_drv) | (~socket_select_oe & SOCK_ID_PULL);
  assign trust_agent_strap    = trust_agent_oe ? trust_agent_drv : TRUST_AGENT_PULL;
  assign trust_platform_strap = trust_platform_oe ? trust_platform_drv : TRUST_PLAT_PULL;
  assign firmware_agent_strap = firmware_agent_oe ? firmware_agent_drv : FW_AGENT_PULL;

  modport dev (
    output thermal_shutdown_n,
    input  supply_ok_in, hard_reset_n,
    input  socket_select_strap, trust_agent_strap, trust_platform_strap, firmware_agent_strap
  );

  modport brd (
    input  thermal_shutdown_n,
    output supply_ok_in, hard_reset_n,
    output socket_select_drv, socket_select_oe, trust_agent_drv, trust_agent_oe,
    output trust_platform_drv, trust_platform_oe, firmware_agent_drv, firmware_agent_oe
  );

endinterface : tts_if

// ### verilog/tts_device.sv
// Function
// - assert shutdown on die overtemperature trip
// - poll module temps, trip above firmware limit
// - trip halts execution, turns PLLs off
// - trip stays latched until hard reset
// - trip fires again after reset if hot
// - board samples trip only after power good
// - board removes all rails after a trip
// - socket strap gives address, node, settings
// - socket and firmware straps decide legacy, modes
// - socket strap zero marks the legacy socket
// - board drives trust agent one on legacy if it is the trust agent socket
// - trust agent strap: zero no, one yes
// - undriven socket, agent straps read zero
// - platform strap: one enabled, pulled up
// - board drives equal platform strap everywhere
// - trusted execution waits for software enable
// - hard reset: known state, drop caches
// - board raises power good clean, monotonic
`timescale 1ns/100ps
module tts_device
  import tts_pkg::*;
#(
  parameter int unsigned POLL_CYCLES = MEM_POLL_CYCLES,
  parameter int unsigned MODULES     = MEM_MODULES,
  parameter int unsigned TEMP_W      = MEM_TEMP_W
) (
  // clock and reset
  input  wire logic                       i_clk,
  input  wire logic                       i_rstn,
  // pins toward the board
  tts_if.dev                              pins,
  // die temperature monitor
  input  wire logic                       i_die_temp_trip,
  // memory module temperature poll
  output logic                            o_mem_poll,
  output logic [$clog2(MODULES)-1:0]      o_mem_poll_idx,
  input  wire logic                       i_mem_temp_valid,
  input  wire logic [$clog2(MODULES)-1:0] i_mem_temp_idx,
  input  wire logic [TEMP_W-1:0]          i_mem_temp,
  input  wire logic [TEMP_W-1:0]          i_mem_temp_limit,
  // core control
  output logic                            o_exec_halt,
  output logic                            o_pll_off,
  output logic                            o_cache_invalidate,
  output logic                            o_in_reset,
  // firmware control of trusted execution
  input  wire logic                       i_trust_sw_enable,
  // decoded socket settings
  output logic                            o_straps_valid,
  output logic [SOCK_ID_W-1:0]            o_node_id,
  output logic [7:0]                      o_mgmt_addr,
  output logic                            o_legacy_socket,
  output logic                            o_fw_agent_present,
  output logic                            o_chipset_pcie_mode,
  output logic                            o_trust_agent,
  output logic                            o_trust_platform,
  output logic                            o_trust_active
);

  localparam int unsigned IDX_W = $clog2(MODULES);
  localparam int unsigned PCNT_W = $clog2(POLL_CYCLES + 1);
  localparam int unsigned SCNT_W = $clog2(STRAP_SETTLE_CYC + 1);
  localparam logic [PCNT_W-1:0] POLL_LAST  = PCNT_W'(POLL_CYCLES - 1);
  localparam logic [SCNT_W-1:0] SETTLE_TOP = SCNT_W'(STRAP_SETTLE_CYC);
  localparam logic [IDX_W-1:0]  IDX_LAST   = IDX_W'(MODULES - 1);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers; stage one feeds stage two only
  logic [PIN_COUNT-1:0] pin_raw;
  logic [PIN_COUNT-1:0] pin_meta;
  logic [PIN_COUNT-1:0] pin_sync;

  assign pin_raw = {pins.supply_ok_in, pins.hard_reset_n, pins.socket_select_strap,
                    pins.trust_agent_strap, pins.trust_platform_strap, pins.firmware_agent_strap};

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pin_meta <= PIN_SYNC_RESET;
      pin_sync <= PIN_SYNC_RESET;
    end else begin
      pin_meta <= pin_raw;
      pin_sync <= pin_meta;
    end
  end

  logic supply_ok;
  logic hard_rst;
  assign supply_ok = pin_sync[PIN_SUPPLY_OK];
  // hard reset reads as asserted until the synchroniser has filled
  assign hard_rst  = ~pin_sync[PIN_HARD_RSTN];

  ////////////////////////////////////////////////////////////////////////////
  // reset state of the core
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_in_reset         <= 1'b1;
      o_cache_invalidate <= 1'b1;
    end else begin
      o_in_reset         <= hard_rst | ~supply_ok;
      // caches are dropped, never written back, so dirty lines are lost by design
      o_cache_invalidate <= hard_rst;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // memory module poll
  logic [PCNT_W-1:0] poll_cnt;
  logic              polling;
  assign polling = supply_ok & ~hard_rst;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      poll_cnt       <= '0;
      o_mem_poll     <= 1'b0;
      o_mem_poll_idx <= '0;
    end else if (!polling) begin
      poll_cnt       <= '0;
      o_mem_poll     <= 1'b0;
      o_mem_poll_idx <= '0;
    end else if (poll_cnt == POLL_LAST) begin
      poll_cnt       <= '0;
      o_mem_poll     <= 1'b1;
      o_mem_poll_idx <= (o_mem_poll_idx == IDX_LAST) ? '0 : o_mem_poll_idx + IDX_W'(1);
    end else begin
      poll_cnt   <= poll_cnt + PCNT_W'(1);
      o_mem_poll <= 1'b0;
    end
  end

  // one over-limit flag per module, refreshed by each answer
  logic [MODULES-1:0] mem_over;

  for (genvar m = 0; m < MODULES; m++) begin : g_mem
    always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
        mem_over[m] <= 1'b0;
      end else if (hard_rst) begin
        mem_over[m] <= 1'b0;
      end else if (i_mem_temp_valid && i_mem_temp_idx == IDX_W'(m)) begin
        mem_over[m] <= (i_mem_temp > i_mem_temp_limit);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // thermal trip latch
  logic tripped;
  logic trip_cause;
  assign trip_cause = i_die_temp_trip | (|mem_over);

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      tripped <= 1'b0;
    end else if (hard_rst) begin
      tripped <= 1'b0;
    end else if (supply_ok && trip_cause) begin
      // a cause still present after reset release trips again here
      tripped <= 1'b1;
    end
  end

  assign pins.thermal_shutdown_n = ~tripped;
  assign o_exec_halt = tripped;
  assign o_pll_off   = tripped;

  ////////////////////////////////////////////////////////////////////////////
  // strap capture, once per power good cycle
  logic [SCNT_W-1:0] settle_cnt;
  logic              captured;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      settle_cnt <= '0;
      captured   <= 1'b0;
    end else if (!supply_ok) begin
      settle_cnt <= '0;
      captured   <= 1'b0;
    end else if (!captured) begin
      if (settle_cnt == SETTLE_TOP) begin
        captured <= 1'b1;
      end else begin
        settle_cnt <= settle_cnt + SCNT_W'(1);
      end
    end
  end

  logic [SOCK_ID_W-1:0] sock_id;
  logic                 agent_strap;
  logic                 plat_strap;
  logic                 fw_strap;

  // pull defaults stand in the registers until the first capture
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      sock_id     <= SOCK_ID_PULL;
      agent_strap <= TRUST_AGENT_PULL;
      plat_strap  <= TRUST_PLAT_PULL;
      fw_strap    <= FW_AGENT_PULL;
    end else if (supply_ok && !captured && settle_cnt == SETTLE_TOP) begin
      sock_id     <= pin_sync[PIN_SOCK_HI:PIN_SOCK_LO];
      agent_strap <= pin_sync[PIN_TRUST_AGT];
      plat_strap  <= pin_sync[PIN_TRUST_PLAT];
      fw_strap    <= pin_sync[PIN_FW_AGENT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // decoded socket settings
  logic legacy;
  assign legacy = (sock_id == LEGACY_SOCKET_SELECT_STRAP);

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_straps_valid      <= 1'b0;
      o_node_id           <= '0;
      o_mgmt_addr         <= MGMT_ADDR_BASE;
      o_legacy_socket     <= 1'b0;
      o_fw_agent_present  <= 1'b0;
      o_chipset_pcie_mode <= 1'b0;
      o_trust_agent       <= TRUST_AGENT_PULL;
      o_trust_platform    <= TRUST_PLAT_PULL;
    end else begin
      o_straps_valid      <= captured;
      o_node_id           <= sock_id;
      o_mgmt_addr         <= MGMT_ADDR_BASE + {6'h00, sock_id};
      o_legacy_socket     <= legacy;
      o_fw_agent_present  <= legacy & fw_strap;
      // only the booting legacy socket keeps the native chipset link
      o_chipset_pcie_mode <= ~(legacy & fw_strap);
      o_trust_agent       <= agent_strap;
      o_trust_platform    <= plat_strap;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // trusted execution stays off until firmware turns it on
  logic trust_sw_on;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      trust_sw_on <= 1'b0;
    end else if (hard_rst || !captured) begin
      trust_sw_on <= 1'b0;
    end else if (i_trust_sw_enable && plat_strap) begin
      trust_sw_on <= 1'b1;
    end
  end

  assign o_trust_active = trust_sw_on;

endmodule : tts_device

// ### verilog/tts_board.sv
`timescale 1ns/100ps
module tts_board
  import tts_pkg::*;
(
  // clock and reset
  input  wire logic                 i_clk,
  input  wire logic                 i_rstn,
  // pins toward the device
  tts_if.brd                        pins,
  // power sequencing
  input  wire logic                 i_power_request,
  input  wire logic                 i_supplies_stable,
  input  wire logic                 i_hard_reset_req,
  input  wire logic                 i_trip_ack,
  output logic                      o_rails_on,
  output logic                      o_trip_seen,
  // strap settings of this socket
  input  wire logic [SOCK_ID_W-1:0] i_socket_select_strap,
  input  wire logic                 i_socket_select_strap_drive,
  input  wire logic                 i_trust_agent_socket,
  input  wire logic                 i_platform_trust,
  input  wire logic                 i_firmware_agent
);

  ////////////////////////////////////////////////////////////////////////////
  // trip pin synchroniser
  logic trip_meta;
  logic trip_n_sync;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      trip_meta   <= 1'b1;
      trip_n_sync <= 1'b1;
    end else begin
      trip_meta   <= pins.thermal_shutdown_n;
      trip_n_sync <= trip_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // trip capture; a new trip wins over the acknowledge
  logic supply_ok;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_trip_seen <= 1'b0;
    end else if (supply_ok && !trip_n_sync) begin
      o_trip_seen <= 1'b1;
    end else if (i_trip_ack && trip_n_sync) begin
      // an ack while the pin still reads low would pulse power good back on for a cycle
      o_trip_seen <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // rails and power good
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_rails_on <= 1'b0;
      supply_ok  <= 1'b0;
    end else begin
      // every rail drops together, core, termination, agent, pll and memory
      o_rails_on <= i_power_request & ~o_trip_seen & ~(supply_ok & ~trip_n_sync);
      // registered so it cannot glitch, and held low until rails have settled
      supply_ok  <= o_rails_on & i_supplies_stable & ~(supply_ok & ~trip_n_sync);
    end
  end

  assign pins.supply_ok_in = supply_ok;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pins.hard_reset_n <= 1'b0;
    end else begin
      pins.hard_reset_n <= ~i_hard_reset_req;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // strap drivers
  logic is_legacy;
  assign is_legacy = (i_socket_select_strap == LEGACY_SOCKET_SELECT_STRAP);

  assign pins.socket_select_drv  = i_socket_select_strap;
  assign pins.socket_select_oe   = {SOCK_ID_W{i_socket_select_strap_drive}};
  assign pins.trust_agent_drv    = is_legacy & i_trust_agent_socket;
  assign pins.trust_agent_oe     = is_legacy & i_trust_agent_socket;
  // one platform input feeds every socket's strap
  assign pins.trust_platform_drv = i_platform_trust;
  assign pins.trust_platform_oe  = 1'b1;
  assign pins.firmware_agent_drv = i_firmware_agent;
  assign pins.firmware_agent_oe  = 1'b1;

endmodule : tts_board

// ### tb/tts_assertions.sv
`timescale 1ns/100ps
module tts_assertions (
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_rstn,
  // interface pins
  input  wire logic thermal_shutdown_n,
  input  wire logic supply_ok_in,
  input  wire logic hard_reset_n,
  // device side
  input  wire logic o_exec_halt,
  input  wire logic o_pll_off,
  input  wire logic o_cache_invalidate,
  input  wire logic o_straps_valid,
  input  wire logic o_trust_active,
  input  wire logic i_trust_sw_enable
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  ////////////////////////////////////////////////////////////////////////////
  logic [5:0] pg_cnt;
  // saturates so a long power good never wraps back into the window
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) pg_cnt <= 6'h00;
    else if (!supply_ok_in) pg_cnt <= 6'h00;
    else if (pg_cnt != 6'h3F) pg_cnt <= pg_cnt + 6'h01;
  end

  sequence s_hard_reset_held;
    !hard_reset_n [*4];
  endsequence
  sequence s_power_lost;
    // two sync flops, the capture flag and the valid register lie between the pin and the output
    !supply_ok_in [*5];
  endsequence

  ////////////////////////////////////////////////////////////////////////////
  a_trip_needs_power: assert property ($fell(thermal_shutdown_n) |-> $past(supply_ok_in, 3) && $past(hard_reset_n, 3))
    else $error("shutdown fell without power good or during hard reset");
  a_trip_latched: assert property ($rose(thermal_shutdown_n) |-> !$past(hard_reset_n, 3))
    else $error("shutdown released without hard reset");
  a_trip_stops_core: assert property ((o_exec_halt == !thermal_shutdown_n) && (o_pll_off == !thermal_shutdown_n))
    else $error("halt or pll off disagrees with shutdown");
  a_reset_clears_trip: assert property (s_hard_reset_held |-> thermal_shutdown_n && o_cache_invalidate)
    else $error("hard reset did not clear trip or drop caches");
  a_board_drops_power: assert property ($fell(thermal_shutdown_n) |-> ##[1:6] !supply_ok_in)
    else $error("board kept power good after a trip");
  a_straps_settle_time: assert property ($rose(o_straps_valid) |-> pg_cnt >= 6'h14 && pg_cnt <= 6'h1B)
    else $error("strap capture outside the settle window");
  a_straps_drop_valid: assert property (s_power_lost |-> !o_straps_valid)
    else $error("straps valid without power good");
  a_trust_waits_sw: assert property ($rose(o_trust_active) |-> $past(i_trust_sw_enable) && o_straps_valid)
    else $error("trusted execution active without software enable");
endmodule : tts_assertions

// ### tb/thermal_trip_and_boot_straps_test.sv
`timescale 1ns/100ps
module thermal_trip_and_boot_straps_test;
  import tts_pkg::*;
  localparam int unsigned POLL = 16;
  // {id[1:0], drive, trust agent ask, platform, firmware agent}
  localparam logic [5:0] CASES [5] = '{6'h0F, 6'h1D, 6'h2A, 6'h39, 6'h32};

  logic       i_clk, i_rstn, i_die_temp_trip, i_mem_temp_valid, i_trust_sw_enable;
  logic [1:0] i_mem_temp_idx, o_mem_poll_idx, o_node_id, i_socket_select_strap, e_id, idx;
  logic [7:0] i_mem_temp, i_mem_temp_limit, o_mgmt_addr;
  logic       o_mem_poll, o_exec_halt, o_pll_off, o_cache_invalidate, o_straps_valid;
  logic       o_legacy_socket, o_fw_agent_present, o_chipset_pcie_mode, o_trust_agent;
  logic       o_trust_platform, o_trust_active, o_rails_on, o_trip_seen, e_leg, o_in_reset;
  logic       i_power_request, i_supplies_stable, i_hard_reset_req, i_trip_ack;
  logic       i_socket_select_strap_drive, i_trust_agent_socket, i_platform_trust, i_firmware_agent;
  int         fail_count, comparisons, n;

  tts_if u_tts_if ();
  tts_device #(.POLL_CYCLES(POLL)) u_tts_device (.i_clk(i_clk), .i_rstn(i_rstn), .pins(u_tts_if),
    .i_die_temp_trip(i_die_temp_trip), .o_mem_poll(o_mem_poll), .o_mem_poll_idx(o_mem_poll_idx),
    .i_mem_temp_valid(i_mem_temp_valid), .i_mem_temp_idx(i_mem_temp_idx), .i_mem_temp(i_mem_temp),
    .i_mem_temp_limit(i_mem_temp_limit), .o_exec_halt(o_exec_halt), .o_pll_off(o_pll_off),
    .o_cache_invalidate(o_cache_invalidate), .o_in_reset(o_in_reset), .i_trust_sw_enable(i_trust_sw_enable),
    .o_straps_valid(o_straps_valid), .o_node_id(o_node_id), .o_mgmt_addr(o_mgmt_addr),
    .o_legacy_socket(o_legacy_socket), .o_fw_agent_present(o_fw_agent_present),
    .o_chipset_pcie_mode(o_chipset_pcie_mode), .o_trust_agent(o_trust_agent),
    .o_trust_platform(o_trust_platform), .o_trust_active(o_trust_active));
  tts_board u_tts_board (.i_clk(i_clk), .i_rstn(i_rstn), .pins(u_tts_if), .i_power_request(i_power_request),
    .i_supplies_stable(i_supplies_stable), .i_hard_reset_req(i_hard_reset_req), .i_trip_ack(i_trip_ack),
    .o_rails_on(o_rails_on), .o_trip_seen(o_trip_seen), .i_socket_select_strap(i_socket_select_strap),
    .i_socket_select_strap_drive(i_socket_select_strap_drive), .i_trust_agent_socket(i_trust_agent_socket),
    .i_platform_trust(i_platform_trust), .i_firmware_agent(i_firmware_agent));
  tts_assertions u_tts_assertions (.i_clk(i_clk), .i_rstn(i_rstn),
    .thermal_shutdown_n(u_tts_if.thermal_shutdown_n), .supply_ok_in(u_tts_if.supply_ok_in),
    .hard_reset_n(u_tts_if.hard_reset_n), .o_exec_halt(o_exec_halt), .o_pll_off(o_pll_off),
    .o_cache_invalidate(o_cache_invalidate), .o_straps_valid(o_straps_valid),
    .o_trust_active(o_trust_active), .i_trust_sw_enable(i_trust_sw_enable));

  ////////////////////////////////////////////////////////////////////////////
  task check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // bounded wait, a miss counts as a mismatch
  task automatic wait_sig(ref logic s, input logic v, input string name);
    int k;
    for (k = 0; k < 400 && s !== v; k++) @(negedge i_clk);
    check(name, s, v);
  endtask : wait_sig

  task send_temp(input logic [1:0] id, input logic [7:0] t);
    i_mem_temp_valid = 1'h1;
    i_mem_temp_idx   = id;
    i_mem_temp       = t;
    @(negedge i_clk);
    i_mem_temp_valid = 1'h0;
  endtask : send_temp

  task end_of_test;
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_of_test

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    i_clk = 1'h0;
    forever #2.5 i_clk = ~i_clk;
  end

  initial begin
    repeat (40000) @(posedge i_clk);
    fail_count++;
    end_of_test;
  end

  initial begin
    {i_die_temp_trip, i_mem_temp_valid, i_trust_sw_enable, i_power_request, i_hard_reset_req} = 5'h00;
    {i_trip_ack, i_socket_select_strap_drive, i_trust_agent_socket, i_platform_trust, i_firmware_agent} = 5'h00;
    {i_mem_temp_idx, i_socket_select_strap, i_mem_temp} = 12'h000;
    i_mem_temp_limit  = 8'h50;
    i_supplies_stable = 1'h1;
    i_rstn = 1'h0;
    repeat (20) @(negedge i_clk);
    i_rstn = 1'h1;
    for (int c = 0; c < 5; c++) begin
      i_power_request = 1'h0;
      wait_sig(o_straps_valid, 1'h0, "valid_down");
      repeat (4) @(negedge i_clk);
      {i_socket_select_strap, i_socket_select_strap_drive, i_trust_agent_socket, i_platform_trust, i_firmware_agent} = CASES[c];
      e_id  = i_socket_select_strap_drive ? i_socket_select_strap : 2'h0;
      e_leg = (e_id == LEGACY_SOCKET_SELECT_STRAP);
      i_power_request = 1'h1;
      wait_sig(o_straps_valid, 1'h1, "valid_up");
      check("node_id", o_node_id, e_id);
      check("mgmt_addr", o_mgmt_addr, MGMT_ADDR_BASE + e_id);
      check("legacy", o_legacy_socket, e_leg);
      check("fw_agent", o_fw_agent_present, e_leg & i_firmware_agent);
      // logical not keeps the expectation one bit wide inside the byte compare
      check("pcie_mode", o_chipset_pcie_mode, !(e_leg & i_firmware_agent));
      check("trust_agent", o_trust_agent, e_leg & i_trust_agent_socket);
      check("trust_platform", o_trust_platform, i_platform_trust);
      check("trust_idle", o_trust_active, 1'h0);
      i_socket_select_strap = ~i_socket_select_strap;
      i_trust_sw_enable = 1'h1;
      @(negedge i_clk);
      i_trust_sw_enable = 1'h0;
      repeat (30) @(negedge i_clk);
      check("trust_active", o_trust_active, i_platform_trust);
      check("node_held", o_node_id, e_id);
    end
    // module temperature poll, spacing and index
    wait_sig(o_mem_poll, 1'h1, "poll");
    idx = o_mem_poll_idx;
    for (n = 1; n < 100; n++) begin
      @(negedge i_clk);
      if (o_mem_poll === 1'h1) break;
    end
    check("poll_spacing", n, POLL);
    // the index wraps at two bits
    check("poll_idx", o_mem_poll_idx, 2'(idx + 2'h1));
    // equal to the limit is not over it
    send_temp(2'h2, 8'h50);
    repeat (4) @(negedge i_clk);
    check("no_trip_equal", u_tts_if.thermal_shutdown_n, 1'h1);
    send_temp(2'h2, 8'h51);
    repeat (2) @(negedge i_clk);
    check("mem_trip", u_tts_if.thermal_shutdown_n, 1'h0);
    check("exec_halt", o_exec_halt, 1'h1);
    check("pll_off", o_pll_off, 1'h1);
    send_temp(2'h2, 8'h10);
    repeat (6) @(negedge i_clk);
    check("trip_latched", u_tts_if.thermal_shutdown_n, 1'h0);
    check("trip_seen", o_trip_seen, 1'h1);
    check("rails_off", o_rails_on, 1'h0);
    check("power_good_off", u_tts_if.supply_ok_in, 1'h0);
    i_hard_reset_req = 1'h1;
    wait_sig(u_tts_if.thermal_shutdown_n, 1'h1, "trip_cleared");
    check("cache_invalidate", o_cache_invalidate, 1'h1);
    check("in_reset", o_in_reset, 1'h1);
    // ack once the released pin has passed the board's synchroniser, then power returns
    repeat (3) @(negedge i_clk);
    i_trip_ack = 1'h1;
    @(negedge i_clk);
    i_trip_ack = 1'h0;
    wait_sig(u_tts_if.supply_ok_in, 1'h1, "power_back");
    repeat (3) @(negedge i_clk);
    // a cause during hard reset is refused
    i_die_temp_trip = 1'h1;
    @(negedge i_clk);
    i_die_temp_trip = 1'h0;
    repeat (4) @(negedge i_clk);
    check("refused", u_tts_if.thermal_shutdown_n, 1'h1);
    // still hot when hard reset is released
    i_die_temp_trip  = 1'h1;
    i_hard_reset_req = 1'h0;
    wait_sig(u_tts_if.thermal_shutdown_n, 1'h0, "re_trip");
    check("in_reset_off", o_in_reset, 1'h0);
    i_die_temp_trip = 1'h0;
    repeat (4) @(negedge i_clk);
    end_of_test;
  end
endmodule : thermal_trip_and_boot_straps_test
